// ### ctzc_cfg_if.sv
// ctzc_cfg_if: raw register fields out to the decoder and decoded physical values back
// assumes: the decoder is purely combinational
`timescale 1ns/1ns
interface ctzc_cfg_if;
  import ctzc_pkg::*;
  logic [2:0] upper_sel;
  logic [2:0] lower_sel;
  logic [1:0] volt_sel [CTZC_NZONES];
  logic [2:0] curr_sel [CTZC_NZONES];
  logic signed [7:0] upper_temp;
  logic signed [7:0] lower_temp;
  logic [11:0] volt_mv [CTZC_NZONES];
  logic [9:0] curr_pm [CTZC_NZONES];

  modport regs (
    output upper_sel, lower_sel, volt_sel, curr_sel,
    input upper_temp, lower_temp, volt_mv, curr_pm
  );
  modport dec (
    input upper_sel, lower_sel, volt_sel, curr_sel,
    output upper_temp, lower_temp, volt_mv, curr_pm
  );
endinterface : ctzc_cfg_if

// ### ctzc_decode.sv
// ctzc_decode: table lookup from register codes to degrees, millivolts and per-mille
// assumes: codes come from registers on the same clock; outputs are registered by the user
`timescale 1ns/1ns
module ctzc_decode
  import ctzc_pkg::*;
(
  ctzc_cfg_if.dec cfg
);

  // thresholds share one encoding for both edges of the middle zone
  assign cfg.upper_temp = CTZC_TEMP_TBL[cfg.upper_sel];
  assign cfg.lower_temp = CTZC_TEMP_TBL[cfg.lower_sel];

  // identical voltage and current tables for the middle and hot zones
  for (genvar z = 0; z < CTZC_NZONES; z++) begin : g_zone
    assign cfg.volt_mv[z] = CTZC_VOLT_TBL[cfg.volt_sel[z]];
    assign cfg.curr_pm[z] = CTZC_CURR_TBL[cfg.curr_sel[z]];
  end

endmodule : ctzc_decode

// ### ctzc_pkg.sv
// ctzc_pkg: constants, field layout and decode tables for the charger temperature-zone registers
// assumes: an apb slave whose registers each take one aligned 32-bit word (byte address = index * 4)
package ctzc_pkg;

  // register indices and apb byte addresses
  localparam int CTZC_ADDR_W = 12;
  localparam logic [7:0] CTZC_IDX_UPPER = 8'h08;
  localparam logic [7:0] CTZC_IDX_HOT = 8'h09;
  localparam logic [7:0] CTZC_IDX_LOWER = 8'h10;
  localparam logic [CTZC_ADDR_W-1:0] CTZC_ADDR_UPPER = {2'h0, CTZC_IDX_UPPER, 2'h0};
  localparam logic [CTZC_ADDR_W-1:0] CTZC_ADDR_HOT = {2'h0, CTZC_IDX_HOT, 2'h0};
  localparam logic [CTZC_ADDR_W-1:0] CTZC_ADDR_LOWER = {2'h0, CTZC_IDX_LOWER, 2'h0};

  // values after reset
  localparam logic [7:0] CTZC_RST_UPPER = 8'he3;
  localparam logic [7:0] CTZC_RST_HOT = 8'hc0;
  localparam logic [2:0] CTZC_RST_LOWER = 3'h5;

  // field positions: upper zone register
  localparam int CTZC_UP_THR_LSB = 5;
  localparam int CTZC_UP_VOLT_LSB = 3;
  localparam int CTZC_UP_CURR_LSB = 0;
  // field positions: hot zone and termination register
  localparam int CTZC_HOT_RSVD_BIT = 7;
  localparam int CTZC_HOT_RECHG_BIT = 6;
  localparam int CTZC_HOT_NOTERM_BIT = 5;
  localparam int CTZC_HOT_VOLT_LSB = 3;
  localparam int CTZC_HOT_CURR_LSB = 0;
  // field position: lower threshold register
  localparam int CTZC_LO_THR_LSB = 0;

  // zone indices into the per-zone setting arrays
  localparam int CTZC_NZONES = 2;
  localparam int CTZC_Z_MID = 0;
  localparam int CTZC_Z_HOT = 1;

  // threshold code to degrees c (two's complement)
  localparam logic signed [7:0] CTZC_TEMP_TBL [0:7] = '{
    8'hf6, 8'h00, 8'h0a, 8'h0f, 8'h28, 8'h2d, 8'h32, 8'h3c};
  // termination voltage code to millivolts
  localparam logic [11:0] CTZC_VOLT_TBL [0:3] = '{12'h7d0, 12'h802, 12'h81b, 12'h834};
  // current code to per-mille of the resistor-programmed current
  localparam logic [9:0] CTZC_CURR_TBL [0:7] = '{
    10'h000, 10'h0fa, 10'h177, 10'h1f4, 10'h271, 10'h2ee, 10'h36b, 10'h3e8};

  // temperature zone reported to the charger
  typedef enum logic [1:0] {
    CTZC_ZONE_COLD = 2'b00,
    CTZC_ZONE_MID = 2'b01,
    CTZC_ZONE_HOT = 2'b10
  } ctzc_zone_e;

endpackage : ctzc_pkg

// ### ctzc_regs.sv
// ctzc_regs: apb register bank for charger temperature-zone settings and zone selection
// assumes: apb master on sys_clk; charger status inputs and sensed temperature are asynchronous
`timescale 1ns/1ns
module ctzc_regs
  import ctzc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CTZC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [7:0] measured_temp,
  input wire logic battery_low_voltage,
  input wire logic low_charge_current,
  output logic [1:0] temp_zone,
  output logic [11:0] term_voltage_mv,
  output logic [9:0] charge_current_permille,
  output logic auto_recharge_request,
  output logic charge_terminate_request
);

  ctzc_cfg_if cfg ();

  logic [7:0] charge_upper_zone_config;
  logic [6:0] charge_hot_zone_and_termination_config; // bit 7 is a constant
  logic [2:0] lower_zone_config;

  // two-flop synchronisers; the sensed temperature bus is assumed to change slowly
  // against sys_clk, so a bus-wide skew shows at most one sample of a mixed code
  logic signed [7:0] temp_meta;
  logic signed [7:0] temp_sync;
  logic vbat_meta;
  logic vbat_sync;
  logic ilow_meta;
  logic ilow_sync;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      temp_meta <= 8'h00;
      temp_sync <= 8'h00;
      vbat_meta <= 1'b0;
      vbat_sync <= 1'b0;
      ilow_meta <= 1'b0;
      ilow_sync <= 1'b0;
    end else if (ce) begin
      temp_meta <= measured_temp;
      temp_sync <= temp_meta;
      vbat_meta <= battery_low_voltage;
      vbat_sync <= vbat_meta;
      ilow_meta <= low_charge_current;
      ilow_sync <= ilow_meta;
    end
  end

  // apb decode: one word per register, anything else answers with an error
  wire sel_upper = (paddr == CTZC_ADDR_UPPER);
  wire sel_hot = (paddr == CTZC_ADDR_HOT);
  wire sel_lower = (paddr == CTZC_ADDR_LOWER);
  wire addr_hit = sel_upper | sel_hot | sel_lower;
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  // writes land on the single access edge; only byte lane 0 carries register bits
  wire wr_ok = ce & access_ph & pwrite & addr_hit & pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];

  // zero wait states; a frozen block holds the master off
  assign pready = ce;
  assign pslverr = access_ph & ~addr_hit;

  // read view of the hot register: reserved top bit always reads one
  wire [7:0] hot_view = {1'b1, charge_hot_zone_and_termination_config};
  wire [7:0] rd_byte = sel_upper ? charge_upper_zone_config :
                       sel_hot ? hot_view :
                       sel_lower ? {5'h00, lower_zone_config} : 8'h00;

  // read data is captured in the setup cycle so it leaves from a flip-flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup_ph) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      charge_upper_zone_config <= CTZC_RST_UPPER;
      charge_hot_zone_and_termination_config <= CTZC_RST_HOT[6:0];
      lower_zone_config <= CTZC_RST_LOWER;
    end else if (wr_ok) begin
      if (sel_upper) begin
        charge_upper_zone_config <= wbyte;
      end else if (sel_hot) begin
        charge_hot_zone_and_termination_config <= wbyte[6:0];
      end else if (sel_lower) begin
        lower_zone_config <= wbyte[2:0];
      end
    end
  end

  // field extraction towards the decoder
  assign cfg.upper_sel = charge_upper_zone_config[CTZC_UP_THR_LSB +: 3];
  assign cfg.lower_sel = lower_zone_config[CTZC_LO_THR_LSB +: 3];
  assign cfg.volt_sel[CTZC_Z_MID] = charge_upper_zone_config[CTZC_UP_VOLT_LSB +: 2];
  assign cfg.curr_sel[CTZC_Z_MID] = charge_upper_zone_config[CTZC_UP_CURR_LSB +: 3];
  assign cfg.volt_sel[CTZC_Z_HOT] = charge_hot_zone_and_termination_config[CTZC_HOT_VOLT_LSB +: 2];
  assign cfg.curr_sel[CTZC_Z_HOT] = charge_hot_zone_and_termination_config[CTZC_HOT_CURR_LSB +: 3];

  wire auto_recharge_enable = charge_hot_zone_and_termination_config[CTZC_HOT_RECHG_BIT];
  wire low_current_termination_disable =
    charge_hot_zone_and_termination_config[CTZC_HOT_NOTERM_BIT];

  ctzc_decode u_decode (
    .cfg(cfg)
  );

  // zone selection: hot strictly above upper, middle from lower up to upper
  wire is_hot = (temp_sync > cfg.upper_temp);
  wire is_mid = ~is_hot & (temp_sync >= cfg.lower_temp);
  ctzc_zone_e next_zone;
  assign next_zone = is_hot ? CTZC_ZONE_HOT : (is_mid ? CTZC_ZONE_MID : CTZC_ZONE_COLD);

  // cold zone has no settings of its own here, so it allows no fast charge current
  wire [11:0] next_volt = is_hot ? cfg.volt_mv[CTZC_Z_HOT] : cfg.volt_mv[CTZC_Z_MID];
  wire [9:0] next_curr = is_hot ? cfg.curr_pm[CTZC_Z_HOT] :
                         is_mid ? cfg.curr_pm[CTZC_Z_MID] : 10'h000;

  // charger control requests
  wire next_recharge = auto_recharge_enable & vbat_sync;
  wire next_terminate = ~low_current_termination_disable & ilow_sync;

  // registered outputs to the analog charger
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      temp_zone <= CTZC_ZONE_COLD;
      term_voltage_mv <= 12'h000;
      charge_current_permille <= 10'h000;
      auto_recharge_request <= 1'b0;
      charge_terminate_request <= 1'b0;
    end else if (ce) begin
      temp_zone <= next_zone;
      term_voltage_mv <= next_volt;
      charge_current_permille <= next_curr;
      auto_recharge_request <= next_recharge;
      charge_terminate_request <= next_terminate;
    end
  end

endmodule : ctzc_regs

// ### ctzc_regs_chk.sv
// ctzc_regs_chk: port-level checks on the zone register bank
// assumes: bound into ctzc_regs; ce high for the $past figures
`timescale 1ns/1ns
module ctzc_regs_chk
  import ctzc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CTZC_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic battery_low_voltage,
  input wire logic low_charge_current,
  input wire logic [1:0] temp_zone,
  input wire logic [11:0] term_voltage_mv,
  input wire logic [9:0] charge_current_permille,
  input wire logic auto_recharge_request,
  input wire logic charge_terminate_request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // address outside the three mapped words
  wire hole = paddr != CTZC_ADDR_UPPER && paddr != CTZC_ADDR_HOT && paddr != CTZC_ADDR_LOWER;
  a_ready_follows_ce: assert property (pready == ce) else $error("pready differs from ce");
  a_error_on_hole: assert property (pslverr == (psel && penable && hole))
    else $error("pslverr wrong");
  a_hole_reads_zero: assert property (psel && penable && !pwrite && hole |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_volt_in_table: assert property (
    term_voltage_mv inside {12'h000, 12'h7d0, 12'h802, 12'h81b, 12'h834})
    else $error("voltage off table");
  a_curr_in_table: assert property (
    charge_current_permille inside {10'h000, 10'h0fa, 10'h177, 10'h1f4, 10'h271,
    10'h2ee, 10'h36b, 10'h3e8}) else $error("current off table");
  a_cold_no_current: assert property (
    temp_zone == 2'h0 |-> charge_current_permille == 10'h000) else $error("cold zone charges");
  a_recharge_cause: assert property (
    $rose(auto_recharge_request) |-> $past(battery_low_voltage, 3))
    else $error("recharge without low battery");
  a_term_cause: assert property (
    $rose(charge_terminate_request) |-> $past(low_charge_current, 3))
    else $error("terminate without low current");
  // main scenarios reached
  c_hot_zone: cover property (temp_zone == 2'h2);
  c_both_requests: cover property (auto_recharge_request && charge_terminate_request);
  c_hole_error: cover property (pslverr);
endmodule : ctzc_regs_chk

bind ctzc_regs ctzc_regs_chk u_chk (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .battery_low_voltage(battery_low_voltage),
  .low_charge_current(low_charge_current), .temp_zone(temp_zone),
  .term_voltage_mv(term_voltage_mv), .charge_current_permille(charge_current_permille),
  .auto_recharge_request(auto_recharge_request),
  .charge_terminate_request(charge_terminate_request));

// ### tb_charger_temp_zone_config_regs.sv
// tb_charger_temp_zone_config_regs: apb and charger-side checks of ctzc_regs
// assumes: ce tied high and all byte lanes strobed, so every access phase is one cycle
`timescale 1ns/1ns
module tb_charger_temp_zone_config_regs
  import ctzc_pkg::*;
;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, look = 0, blv = 0, lcc = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, e, s;
  logic signed [7:0] temp = 8'sh00;
  logic [1:0] zone;
  logic [11:0] mv;
  logic [9:0] pm;
  logic pready, pslverr, rech, term;
  int miscompares = 0, n_tests = 0, k;
  int qk[$];
  logic [31:0] qe[$];
  int thr[8] = '{-10, 0, 10, 15, 40, 45, 50, 60};
  int mvt[4] = '{2000, 2050, 2075, 2100};
  ctzc_regs dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measured_temp(temp), .battery_low_voltage(blv),
    .low_charge_current(lcc), .temp_zone(zone), .term_voltage_mv(mv),
    .charge_current_permille(pm), .auto_recharge_request(rech), .charge_terminate_request(term));
  initial forever #10 sys_clk = ~sys_clk;
  // watcher at the falling edge, away from the edge where the dut updates
  always @(negedge sys_clk) begin
    if ((psel && penable && pready === 1'b1 && !pwrite) || look) begin
      k = qk.pop_front();
      e = qe.pop_front();
      s = k == 0 ? prdata : {6'h00, zone, mv, pm, rech, term};
      n_tests++;
      if (s !== e) begin
        miscompares++;
        $display("wrong value %s expected %h seen %h", k == 0 ? "prdata" : "outputs", e, s);
      end
    end
  end
  // expected outputs; a cold zone keeps the mid voltage but draws no current
  function automatic logic [31:0] model(logic [7:0] u, logic [7:0] h, logic [2:0] lo,
      logic signed [7:0] t, logic b, logic l);
    logic hz, mz;
    logic [2:0] c;
    hz = t > thr[u[7:5]];
    mz = !hz && t >= thr[lo];
    c = hz ? h[2:0] : u[2:0];
    return {6'h00, hz, mz, 12'(mvt[hz ? h[4:3] : u[4:3]]),
      10'((hz || mz) && c != 0 ? 125 * (c + 1) : 0), h[6] & b, !h[5] & l};
  endfunction : model
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    qk.push_back(0);
    qe.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic look_out(input logic [31:0] x);
    qk.push_back(1);
    qe.push_back(x);
    @(posedge sys_clk);
    look <= 1'b1;
    @(posedge sys_clk);
    look <= 1'b0;
  endtask : look_out
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // hang guard, well beyond the ~1000 cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [7:0] u, h;
    logic [2:0] lo;
    void'($urandom(30326));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CTZC_ADDR_UPPER, 32'he3);
    rd(CTZC_ADDR_HOT, 32'hc0);
    rd(CTZC_ADDR_LOWER, 32'h05);
    apb(1'b1, 12'h028, 32'hff);
    rd(12'h028, 32'h0);
    $display("test reset values done");
    // every code of the upper and hot zone settings fields walked by the loop index, lower threshold and hot bits 7:5 random, temperature near a threshold
    for (int i = 0; i < 40; i++) begin
      u = {3'(i), 2'(i), 3'(i + 3)};
      h = {3'($urandom), 2'(i + 1), 3'(i)};
      lo = 3'($urandom);
      temp <= 8'(thr[$urandom % 8] + int'($urandom % 3) - 1);
      blv <= 1'($urandom);
      lcc <= 1'($urandom);
      apb(1'b1, CTZC_ADDR_UPPER, {24'h0, u});
      apb(1'b1, CTZC_ADDR_HOT, {24'h0, h});
      apb(1'b1, CTZC_ADDR_LOWER, {29'h0, lo});
      repeat (5) @(posedge sys_clk);
      look_out(model(u, h, lo, temp, blv, lcc));
      rd(CTZC_ADDR_UPPER, {24'h0, u});
      rd(CTZC_ADDR_HOT, {24'h0, 1'b1, h[6:0]});
    end
    $display("test random zones done");
    report_and_stop();
  end
endmodule : tb_charger_temp_zone_config_regs
